// ---- wakeup_supervisor_pkg.sv ----
// wakeup_supervisor_pkg: shared constants for the wakeup / reset supervisor
// assumes a timebase tick whose period stands for a fixed number of ohms of timing resistor
package wakeup_supervisor_pkg;

  // interval ratio period : reset delay : reset-high-to-wakeup = 8 : 1 : 4
  localparam int unsigned PERIOD_UNITS = 8;
  localparam int unsigned RESET_DELAY_UNITS = 1;
  localparam int unsigned WAKE_DELAY_UNITS = 4;

  // default ticks per ratio unit (sets the absolute scale of all intervals)
  localparam int unsigned DEFAULT_TICKS_PER_UNIT = 16;

  // wakeup response to the watchdog edge, in ns, and its cycle bound at 125 MHz
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WAKE_RESPONSE_NS = 2000;
  localparam int unsigned WAKE_RESPONSE_CYCLES = WAKE_RESPONSE_NS / CLK_PERIOD_NS;

  // supervisor states
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_RSTDELAY = 3'b001,
    ST_WAKEDELAY = 3'b010,
    ST_CYCLE = 3'b011,
    ST_WDPULSE = 3'b100
  } sup_state_e;

endpackage : wakeup_supervisor_pkg

// ---- wakeup_watchdog_reset_supervisor.sv ----
// wakeup_watchdog_reset_supervisor: wakeup square wave, watchdog check, reset output
// assumes tick and regulationGood come from logic on clk; watchdogInput is a raw pin
`timescale 1ns/10ps
`default_nettype none

module wakeup_watchdog_reset_supervisor
  import wakeup_supervisor_pkg::*;
#(
  parameter int unsigned TICKS_PER_UNIT = DEFAULT_TICKS_PER_UNIT,
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timebase and regulation status
  input wire logic tick,
  input wire logic regulationGood,
  // controller side
  input wire logic watchdogInput,
  output logic wakeup,
  output logic resetOut_n
);

  localparam logic [CNT_W-1:0] HALF_TICKS =
    CNT_W'(PERIOD_UNITS * TICKS_PER_UNIT / 2);
  localparam logic [CNT_W-1:0] PERIOD_TICKS =
    CNT_W'(PERIOD_UNITS * TICKS_PER_UNIT);
  localparam logic [CNT_W-1:0] RSTDLY_TICKS =
    CNT_W'(RESET_DELAY_UNITS * TICKS_PER_UNIT);
  localparam logic [CNT_W-1:0] WAKEDLY_TICKS =
    CNT_W'(WAKE_DELAY_UNITS * TICKS_PER_UNIT);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  sup_state_e state;
  logic [CNT_W-1:0] count;
  logic wdSync1;
  logic wdSync2;
  logic wdPrev;
  logic wdFall;
  logic edgeSeen;

  // true on the tick that finishes an interval of the given length
  function automatic logic lastTick(
    input logic tk,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] limit
  );
    return tk && (cnt == limit - ONE);
  endfunction : lastTick

  // states in which the controller is let out of reset
  function automatic logic releasedState(input sup_state_e st);
    return (st == ST_WAKEDELAY) || (st == ST_CYCLE);
  endfunction : releasedState

  // watchdog pin: two-flop synchroniser, then one more sample for edge compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdSync1 <= 1'b1;
      wdSync2 <= 1'b1;
      wdPrev <= 1'b1;
    end else begin
      wdSync1 <= watchdogInput;
      wdSync2 <= wdSync1;
      wdPrev <= wdSync2;
    end
  end

  // latency is three clocks, far inside the response bound
  assign wdFall = wdPrev & ~wdSync2;

  // supervisor sequence; counts advance only on timebase ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POWERUP;
      count <= '0;
    end else if (!regulationGood) begin
      state <= ST_POWERUP;
      count <= '0;
    end else begin
      case (state)
        ST_POWERUP: begin
          state <= ST_RSTDELAY;
          count <= '0;
        end
        ST_WDPULSE: begin
          // reset pulse after a silent cycle also lasts one reset delay
          state <= ST_RSTDELAY;
          count <= '0;
        end
        ST_RSTDELAY: begin
          if (tick) begin
            if (lastTick(tick, count, RSTDLY_TICKS)) begin
              state <= ST_WAKEDELAY;
              count <= '0;
            end else begin
              count <= count + ONE;
            end
          end
        end
        ST_WAKEDELAY: begin
          if (tick) begin
            if (lastTick(tick, count, WAKEDLY_TICKS)) begin
              state <= ST_CYCLE;
              count <= '0;
            end else begin
              count <= count + ONE;
            end
          end
        end
        ST_CYCLE: begin
          if (tick) begin
            if (lastTick(tick, count, PERIOD_TICKS)) begin
              count <= '0;
              if (!edgeSeen && !wdFall) begin
                state <= ST_WDPULSE;
              end
            end else begin
              count <= count + ONE;
            end
          end
        end
        default: begin
          state <= ST_POWERUP;
          count <= '0;
        end
      endcase
    end
  end

  // one edge per cycle is remembered; extras change nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeSeen <= 1'b0;
    end else if (state != ST_CYCLE) begin
      edgeSeen <= 1'b0;
    end else if (lastTick(tick, count, PERIOD_TICKS)) begin
      edgeSeen <= 1'b0; // new cycle starts clean
    end else if (wdFall) begin
      edgeSeen <= 1'b1;
    end
  end

  // reset output: low outside the timed sequence and during a watchdog pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetOut_n <= 1'b0;
    end else begin
      resetOut_n <= regulationGood && releasedState(state);
    end
  end

  // wakeup: high in first half of each cycle until the watchdog edge answers it
  // first rise comes with the end of the wake delay, not one period later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup <= 1'b0;
    end else if (!regulationGood) begin
      wakeup <= 1'b0;
    end else if (state == ST_WAKEDELAY) begin
      if (lastTick(tick, count, WAKEDLY_TICKS)) begin
        wakeup <= 1'b1;
      end else begin
        wakeup <= 1'b0;
      end
    end else if (state != ST_CYCLE) begin
      wakeup <= 1'b0;
    end else if (lastTick(tick, count, PERIOD_TICKS)) begin
      // a silent cycle goes straight into reset, so no stray rise there
      wakeup <= edgeSeen || wdFall;
    end else if (lastTick(tick, count, HALF_TICKS)) begin
      wakeup <= 1'b0;
    end else if (wdFall && !edgeSeen) begin
      wakeup <= 1'b0;
    end else begin
      wakeup <= wakeup;
    end
  end

endmodule : wakeup_watchdog_reset_supervisor

`default_nettype wire

// ---- wakeup_watchdog_reset_supervisor_chk.sv ----
// checker: port-level timing of wakeup and reset output
// assumes one clk domain; bound onto the supervisor top
`timescale 1ns/10ps
`default_nettype none
module wakeup_watchdog_reset_supervisor_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs seen
  input wire logic tick,
  input wire logic regulationGood,
  input wire logic watchdogInput,
  // outputs seen
  input wire logic wakeup,
  input wire logic resetOut_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // lower bounds except wd_resp_a and tick_pace_a, so they hold for any ticks per unit of 3 or more
  rst_wake_a: assert property (!resetOut_n |-> !wakeup) else $error("wake in reset");
  reg_loss_a: assert property (!regulationGood |=> !resetOut_n) else $error("no reset");
  wd_resp_a: assert property ($fell(watchdogInput) && wakeup |-> ##[1:5] !wakeup)
    else $error("slow wake fall");
  wake_hold_a: assert property ($fell(wakeup) && resetOut_n |=> !wakeup [*8])
    else $error("wake rose early");
  rst_min_a: assert property ($fell(resetOut_n) |=> !resetOut_n [*2])
    else $error("reset too short");
  wake_delay_a: assert property ($rose(resetOut_n) |-> !wakeup [*8])
    else $error("no wake delay");
  rise_ok_a: assert property ($rose(wakeup) |-> resetOut_n && $past(resetOut_n, 8))
    else $error("wake rise in reset");
  tick_pace_a: assert property ($rose(wakeup) || $rose(resetOut_n)
    |-> $past(tick) || $past(tick, 2) || $past(tick, 3)) else $error("move without tick");
  cover property ($fell(watchdogInput) && wakeup);
  cover property ($fell(resetOut_n) && regulationGood);
  cover property ($rose(wakeup));
endmodule : wakeup_watchdog_reset_supervisor_chk
bind wakeup_watchdog_reset_supervisor wakeup_watchdog_reset_supervisor_chk u_chk (.clk(clk),
  .rst_n(rst_n), .tick(tick), .regulationGood(regulationGood), .watchdogInput(watchdogInput),
  .wakeup(wakeup), .resetOut_n(resetOut_n));
`default_nettype wire

// ---- uc_partner.sv ----
// uc_partner: sleeping controller answering wakeup with watchdog pulses
// assumes wakeup registered on clk; mode 0 silent, 1 one pulse, 2 two
`timescale 1ns/10ps
`default_nettype none
module uc_partner (
  // clock
  input wire logic clk,
  // supervisor side
  input wire logic wakeup,
  input wire logic [1:0] mode,
  output logic wdPin
);
  logic prevWake = 0;
  initial wdPin = 1;
  task automatic pulse();
    for (int i = 0; i < mode; i++) begin
      repeat (2) @(posedge clk);
      wdPin <= 0;
      repeat (2) @(posedge clk);
      wdPin <= 1;
    end
  endtask : pulse
  always @(posedge clk) begin
    prevWake <= wakeup;
    if (wakeup && !prevWake && mode != 0) fork pulse(); join_none
  end
endmodule : uc_partner
`default_nettype wire

// ---- wakeup_watchdog_reset_supervisor_test.sv ----
// testbench: reset output edges noted in a queue, checked by a monitor
// assumes ticks per unit of 2 and a random tick stream
`timescale 1ns/10ps
`default_nettype none
module wakeup_watchdog_reset_supervisor_test;
  import wakeup_supervisor_pkg::*;
  logic clk = 0, rst_n = 0, tick = 0, regulationGood = 0, watchdogInput, wakeup, resetOut_n;
  logic prevRst = 0, want;
  localparam int TPU = 2;
  logic tickNow = 0, prevWake = 0, fromReset = 0;
  int ticks = 0, mark = 0, wantTicks;
  logic [1:0] mode = 1;
  int errors = 0, n_checks = 0, seed = 32'haa85;
  logic expQ[$];
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    tick <= 1'($random(seed));
    if (tick) ticks++;
    tickNow = tick;
  end
  wakeup_watchdog_reset_supervisor #(.TICKS_PER_UNIT(TPU)) u_wakeup_watchdog_reset_supervisor (
    .clk(clk), .rst_n(rst_n), .tick(tick), .regulationGood(regulationGood),
    .watchdogInput(watchdogInput), .wakeup(wakeup), .resetOut_n(resetOut_n));
  uc_partner u_uc_partner (.clk(clk), .wakeup(wakeup), .mode(mode), .wdPin(watchdogInput));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // bounded wait until every noted edge was seen
  task automatic drain(input int n);
    for (int i = 0; i < n && expQ.size() > 0; i++) @(posedge clk);
    if (expQ.size() > 0) begin
      errors++;
      $display("[FAIL] resetOut_n expected edge to %b missing", expQ[0]);
      test_done();
    end
  endtask : drain
  // an edge with no note pending is an unexpected reset
  always @(negedge clk) begin
    if (rst_n && resetOut_n !== prevRst) begin
      n_checks++;
      want = (expQ.size() > 0) ? expQ.pop_front() : 1'bx;
      if (resetOut_n !== want) begin
        errors++;
        $display("[FAIL] resetOut_n expected %b seen %b", want, resetOut_n);
      end
    end
    // tick that released reset already belongs to the wake delay
    if (rst_n && resetOut_n === 1'b1 && prevRst === 1'b0) begin
      mark = ticks - tickNow;
      fromReset = 1;
    end
    if (rst_n && wakeup === 1'b1 && prevWake === 1'b0) begin
      n_checks++;
      wantTicks = fromReset ? WAKE_DELAY_UNITS * TPU : PERIOD_UNITS * TPU;
      if (ticks - mark != wantTicks) begin
        errors++;
        $display("[FAIL] wakeup rise ticks expected %0d seen %0d", wantTicks, ticks - mark);
      end
      mark = ticks;
      fromReset = 0;
    end
    prevWake = wakeup;
    prevRst = resetOut_n;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (30) @(posedge clk);
    regulationGood <= 1;
    expQ.push_back(1);
    drain(200);
    repeat (300) @(posedge clk);
    mode <= 2;
    repeat (300) @(posedge clk);
    mode <= 0;
    expQ.push_back(0);
    expQ.push_back(1);
    drain(400);
    mode <= 1;
    repeat (100) @(posedge clk);
    regulationGood <= 0;
    expQ.push_back(0);
    repeat (20) @(posedge clk);
    regulationGood <= 1;
    expQ.push_back(1);
    drain(200);
    repeat (200) @(posedge clk);
    test_done();
  end
endmodule : wakeup_watchdog_reset_supervisor_test
`default_nettype wire
